// *** include/port_stats_consts.svh ***
`ifndef PORT_STATS_CONSTS_SVH
`define PORT_STATS_CONSTS_SVH

// Host register addresses.
`define REG_SEL       8'h79
`define REG_TRIG      8'h7a
`define REG_RES0      8'h80
`define REG_RES1      8'h81
`define REG_RES2      8'h82
`define REG_RES3      8'h83

// Group select codes written to the select register.
`define SEL_PORT_GRP  8'h1c
`define SEL_DROP_GRP  8'h1d

// Per-port window: three windows of 32 counters.
`define PORT_SPAN     8'h20
`define PORT_LAST     8'h5f

// Counter offsets inside a port window.
`define OFS_RX_CTRL   5'h09
`define OFS_RX_PAUSE  5'h0a
`define OFS_RX_BCAST  5'h0b
`define OFS_RX_MCAST  5'h0c
`define OFS_RX_UCAST  5'h0d
`define OFS_BIN_MIN   5'h0e
`define OFS_BIN_TOP   5'h13
`define OFS_TX_LO_OCT 5'h14
`define OFS_TX_HI_OCT 5'h15
`define OFS_TX_LATE   5'h16
`define OFS_TX_PAUSE  5'h17
`define OFS_TX_BCAST  5'h18
`define OFS_TX_MCAST  5'h19
`define OFS_TX_UCAST  5'h1a
`define OFS_TX_DEFER  5'h1b
`define OFS_TX_COLL   5'h1c
`define OFS_TX_EXCESS 5'h1d
`define OFS_TX_ONE    5'h1e
`define OFS_TX_MANY   5'h1f

// Dropped-frame counters: 0x100..0x105, low byte is the trigger value.
`define DROP_BASE     9'h100
`define DROP_LAST     8'h05

// Frame length bin edges in octets and the frame qualifiers.
`define LEN_64        11'h040
`define LEN_128       11'h080
`define LEN_256       11'h100
`define LEN_512       11'h200
`define LEN_1024      11'h400
`define LEN_MAX_DEF   11'h5f2
`define ETYPE_CTRL    16'h8808
`define OPC_PAUSE     16'h0001

// Result word layout.
`define RES_OVF_BIT   31
`define RES_VLD_BIT   30

`endif

// *** include/port_stats_pkg.sv ***
package port_stats_pkg;

  // Fetch sequencer: idle, then one cycle to snapshot and clear.
  typedef enum logic [1:0] {
    FETCH_IDLE = 2'b00,
    FETCH_RUN  = 2'b01
  } fetch_state_t;

  // Which group the pending fetch targets.
  typedef enum logic [1:0] {
    GRP_NONE = 2'b00,
    GRP_PORT = 2'b01,
    GRP_DROP = 2'b11
  } fetch_grp_t;

endpackage

// *** design/port_stats.sv ***
`include "port_stats_consts.svh"

// Operation
// (R1) Count received frames with control EtherType.
// (R2) Count fully qualified received pause frames.
// (R3) Count good broadcast receives only.
// (R4) Count good multicast, not control, not broadcast.
// (R5) Count good received unicast frames.
// (R6) Bin every received frame by length; code bins none under 64 octets and, from 1024 up, none over max_frame_len_in.
// (R7) Sum transmitted good octets per priority.
// (R8) Count late collisions past 512 bit-times.
// (R9) Count transmitted pause frames.
// (R10) Count good transmits by cast type.
// (R11) Count transmits whose first attempt deferred.
// (R12) Count all collisions in half duplex.
// (R13) Count frames abandoned for excessive collisions.
// (R14) Count one-collision and multi-collision successes.
// (R15) Six 16-bit drop counters at 0x100-0x105.
// (R16) Bump drop counter on resource discard.
// (R17) Host writes group select 0x1c first.
// (R18) Host triggers read via counter address write.
// (R19) Result bit 31 flags counter overflow.
// (R20) Bit 30 valid; host rereads while zero.
// (R21) Value returned most significant byte first.
// (R22) Reading a port counter clears it.
// (R23) Drop counters keep value, no flags.
// (R24) Port windows at 0x00, 0x20, 0x40.
// (R25) Increment once at end of frame.
module port_stats
  import port_stats_pkg::*;
#(
  parameter int NP = 3,
  parameter int CW = 30,
  parameter int DW = 16,
  parameter int LW = 11
) (
  // Clock and reset.
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  // Host register port.
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic [7:0]           reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic      [7:0]           reg_rdata_out,
  // Receive frame end, one pulse per frame, with its attributes.
  input  wire logic [NP-1:0]        rx_done_in,
  input  wire logic [NP-1:0]        rx_crc_ok_in,
  input  wire logic [NP-1:0]        rx_bcast_in,
  input  wire logic [NP-1:0]        rx_mcast_in,
  input  wire logic [NP-1:0]        rx_pause_da_in,
  input  wire logic [NP-1:0][15:0]  rx_etype_in,
  input  wire logic [NP-1:0][15:0]  rx_opcode_in,
  input  wire logic [NP-1:0][LW-1:0] rx_len_in,
  input  wire logic [LW-1:0]        max_frame_len_in,
  // Transmit frame end, one pulse per frame, with its attributes.
  input  wire logic [NP-1:0]        tx_done_in,
  input  wire logic [NP-1:0]        tx_ok_in,
  input  wire logic [NP-1:0]        tx_abandon_in,
  input  wire logic [NP-1:0]        tx_hi_prio_in,
  input  wire logic [NP-1:0]        tx_pause_in,
  input  wire logic [NP-1:0]        tx_bcast_in,
  input  wire logic [NP-1:0]        tx_mcast_in,
  input  wire logic [NP-1:0]        tx_deferred_in,
  input  wire logic [NP-1:0][4:0]   tx_coll_num_in,
  input  wire logic [NP-1:0][LW-1:0] tx_len_in,
  // Collision events, one pulse each, and the duplex mode.
  input  wire logic [NP-1:0]        tx_coll_in,
  input  wire logic [NP-1:0]        tx_late_coll_in,
  input  wire logic [NP-1:0]        half_duplex_in,
  // Resource discard pulses.
  input  wire logic [NP-1:0]        tx_drop_in,
  input  wire logic [NP-1:0]        rx_drop_in
);

  typedef logic [31:0][LW-1:0] inc_vec_t;

  // All state of the block; bit CW of each port counter is its overflow flag.
  typedef struct packed {
    logic [NP-1:0][31:0][CW:0] cnt;
    logic [2*NP-1:0][DW-1:0]   drop;
    logic [7:0]                sel;
    logic [7:0]                taddr;
    fetch_state_t              st;
    fetch_grp_t                grp;
    logic [CW-1:0]             res_val;
    logic                      res_ovf;
    logic                      res_vld;
    logic [7:0]                rdata;
  } core_t;

  core_t r;
  core_t n;

  // Length bin for a received frame; 0 means no bin applies.
  function automatic logic [4:0] len_bin(input logic [LW-1:0] len,
                                         input logic [LW-1:0] max_len);
    logic [4:0] b;
    b = 5'h00;
    if (len == `LEN_64)                        b = `OFS_BIN_MIN;
    else if (len > `LEN_64 && len < `LEN_128)  b = 5'h0f;
    else if (len >= `LEN_128 && len < `LEN_256) b = 5'h10;
    else if (len >= `LEN_256 && len < `LEN_512) b = 5'h11;
    else if (len >= `LEN_512 && len < `LEN_1024) b = 5'h12;
    else if (len >= `LEN_1024 && len <= max_len) b = `OFS_BIN_TOP;
    return b;
  endfunction

  // Increment due to each counter of one port in this cycle.
  function automatic inc_vec_t port_inc(
    input logic rxd, rxg, rxb, rxm, rxda,
    input logic [15:0] etype, opcode,
    input logic [LW-1:0] rxl, max_len,
    input logic txd, txok, txab, txhi, txp, txb, txm, txdf,
    input logic [4:0] txc,
    input logic [LW-1:0] txl,
    input logic coll, late, hdx);
    inc_vec_t v;
    logic     ctl;
    logic [4:0] b;
    v   = '0;
    ctl = (etype == `ETYPE_CTRL);
    b   = len_bin(rxl, max_len);
    if (rxd) begin
      v[`OFS_RX_CTRL] = LW'(ctl); // R1 R25
      v[`OFS_RX_PAUSE] = LW'(ctl && rxda && opcode == `OPC_PAUSE &&
                             rxl >= `LEN_64 && rxg); // R2
      v[`OFS_RX_BCAST] = LW'(rxg && rxb); // R3
      v[`OFS_RX_MCAST] = LW'(rxg && rxm && !rxb && !ctl); // R4
      v[`OFS_RX_UCAST] = LW'(rxg && !rxb && !rxm); // R5
      if (b != 5'h00) begin
        v[b] = LW'(1); // R6
      end
    end
    if (txd && txok) begin
      if (txhi) v[`OFS_TX_HI_OCT] = txl; // R7
      else      v[`OFS_TX_LO_OCT] = txl; // R7
      v[`OFS_TX_PAUSE] = LW'(txp); // R9
      v[`OFS_TX_BCAST] = LW'(txb); // R10
      v[`OFS_TX_MCAST] = LW'(txm && !txb); // R10
      v[`OFS_TX_UCAST] = LW'(!txb && !txm); // R10
      v[`OFS_TX_DEFER] = LW'(txdf); // R11
      v[`OFS_TX_ONE]   = LW'(txc == 5'h01); // R14
      v[`OFS_TX_MANY]  = LW'(txc > 5'h01); // R14
    end
    v[`OFS_TX_EXCESS] = LW'(txd && txab); // R13
    v[`OFS_TX_LATE]   = LW'(late); // R8
    v[`OFS_TX_COLL]   = LW'(coll && hdx); // R12
    return v;
  endfunction

  // Next state: host port, fetch sequencer, counters.
  always_comb begin
    inc_vec_t      inc;
    logic          clr;
    logic [CW:0]   sum;
    logic [CW-1:0] base;
    logic          ovf;
    logic [1:0]    fport;
    n     = r;
    inc   = '0;
    clr   = 1'b0;
    sum   = '0;
    base  = '0;
    ovf   = 1'b0;
    fport = r.taddr[6:5]; // R24
    n.rdata = 8'h00;
    // Fetch completes one cycle after the trigger; until then valid is 0.
    if (r.st == FETCH_RUN) begin
      n.st  = FETCH_IDLE;
      n.res_val = '0;
      n.res_ovf = 1'b0;
      n.res_vld = 1'b0;
      if (r.grp == GRP_PORT) begin
        n.res_val = r.cnt[fport][r.taddr[4:0]][CW-1:0]; // R21
        n.res_ovf = r.cnt[fport][r.taddr[4:0]][CW]; // R19
        n.res_vld = 1'b1; // R20
      end else if (r.grp == GRP_DROP) begin
        n.res_val = CW'(r.drop[r.taddr[2:0]]); // R15 R23
      end
    end
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `REG_SEL: n.sel = reg_wdata_in; // R17
        `REG_TRIG: begin
          n.taddr   = reg_wdata_in; // R18
          n.st      = FETCH_RUN;
          n.res_vld = 1'b0; // R20
          if (r.sel == `SEL_PORT_GRP && reg_wdata_in <= `PORT_LAST) begin
            n.grp = GRP_PORT; // R24
          end else if (r.sel == `SEL_DROP_GRP &&
                       reg_wdata_in <= `DROP_LAST) begin
            n.grp = GRP_DROP; // R15
          end else begin
            n.grp = GRP_NONE;
          end
        end
        default: ;
      endcase
    end
    // Read data appear in the cycle after the strobe.
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `REG_SEL:  n.rdata = r.sel;
        `REG_TRIG: n.rdata = r.taddr;
        `REG_RES0: n.rdata = {r.res_ovf, r.res_vld, r.res_val[29:24]}; // R21
        `REG_RES1: n.rdata = r.res_val[23:16]; // R21
        `REG_RES2: n.rdata = r.res_val[15:8]; // R21
        `REG_RES3: n.rdata = r.res_val[7:0]; // R21
        default:   n.rdata = 8'h00;
      endcase
    end
    // Counter update; a frame ending as its counter is cleared still counts.
    for (int p = 0; p < NP; p++) begin
      inc = port_inc(rx_done_in[p], rx_crc_ok_in[p], rx_bcast_in[p],
                     rx_mcast_in[p], rx_pause_da_in[p], rx_etype_in[p],
                     rx_opcode_in[p], rx_len_in[p], max_frame_len_in,
                     tx_done_in[p], tx_ok_in[p], tx_abandon_in[p],
                     tx_hi_prio_in[p], tx_pause_in[p], tx_bcast_in[p],
                     tx_mcast_in[p], tx_deferred_in[p], tx_coll_num_in[p],
                     tx_len_in[p], tx_coll_in[p], tx_late_coll_in[p],
                     half_duplex_in[p]);
      for (int i = 0; i < 32; i++) begin
        clr  = (r.st == FETCH_RUN) && (r.grp == GRP_PORT) &&
               (int'(fport) == p) && (int'(r.taddr[4:0]) == i); // R22
        base = clr ? '0 : r.cnt[p][i][CW-1:0];
        ovf  = clr ? 1'b0 : r.cnt[p][i][CW];
        sum  = {1'b0, base} + (CW+1)'(inc[i]); // R25
        n.cnt[p][i] = {ovf | sum[CW], sum[CW-1:0]}; // R19
      end
      // Drop counters wrap and are never cleared by a read.
      n.drop[p]      = r.drop[p] + DW'(tx_drop_in[p]); // R16 R23
      n.drop[p + NP] = r.drop[p + NP] + DW'(rx_drop_in[p]); // R16
    end
  end

  // The single state register; async reset loads constants only.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata_out = r.rdata;

  // Checks; the event checks watch port 0 and, on r.cnt, skip any cycle with a fetch running; the read-clear check watches the fetched counter.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic quiet0;
  assign quiet0 = (r.st != FETCH_RUN);

  sequence seq_trig_port;
    reg_wr_in && reg_addr_in == `REG_TRIG && r.sel == `SEL_PORT_GRP &&
    reg_wdata_in <= `PORT_LAST;
  endsequence

  sequence seq_fetch_ready;
    !r.res_vld ##1 r.res_vld;
  endsequence

  AST_RX_CTRL: assert property ( // R1
    rx_done_in[0] && rx_etype_in[0] == `ETYPE_CTRL && quiet0 |=>
    r.cnt[0][`OFS_RX_CTRL][CW-1:0] ==
      $past(r.cnt[0][`OFS_RX_CTRL][CW-1:0]) + CW'(1))
    else $error("control frame not counted");

  AST_RX_PAUSE_OPC: assert property ( // R2
    rx_done_in[0] && rx_opcode_in[0] != `OPC_PAUSE && quiet0 |=>
    $stable(r.cnt[0][`OFS_RX_PAUSE]))
    else $error("pause counted with wrong opcode");

  AST_BIN_MIN: assert property ( // R6
    rx_done_in[0] && rx_len_in[0] == `LEN_64 && quiet0 |=>
    r.cnt[0][`OFS_BIN_MIN][CW-1:0] ==
      $past(r.cnt[0][`OFS_BIN_MIN][CW-1:0]) + CW'(1))
    else $error("64 octet bin missed");

  AST_LATE_COLL: assert property ( // R8
    tx_late_coll_in[0] && quiet0 |=>
    r.cnt[0][`OFS_TX_LATE][CW-1:0] ==
      $past(r.cnt[0][`OFS_TX_LATE][CW-1:0]) + CW'(1))
    else $error("late collision not counted");

  AST_FULL_DUPLEX_COLL: assert property ( // R12
    tx_coll_in[0] && !half_duplex_in[0] && quiet0 |=>
    $stable(r.cnt[0][`OFS_TX_COLL]))
    else $error("collision counted in full duplex");

  AST_DROP_INC: assert property ( // R16
    rx_drop_in[0] |=> r.drop[NP] == $past(r.drop[NP]) + DW'(1))
    else $error("receive drop not counted");

  AST_VALID_SEQ: assert property ( // R20
    seq_trig_port |=> seq_fetch_ready)
    else $error("valid flag sequence wrong");

  AST_READ_CLEAR: assert property ( // R22
    seq_trig_port ##1 (rx_done_in == '0 && tx_done_in == '0 &&
      tx_coll_in == '0 && tx_late_coll_in == '0) |=>
    r.cnt[$past(r.taddr[6:5])][$past(r.taddr[4:0])] == '0)
    else $error("port counter not cleared by read");

  AST_LOW_BYTE: assert property ( // R21
    reg_rd_in && reg_addr_in == `REG_RES3 |=>
    reg_rdata_out == $past(r.res_val[7:0]))
    else $error("low result byte wrong");

endmodule

// *** testbench/mgmt_host.sv ***
`include "port_stats_consts.svh"

// Management host model: drives the register port one strobe at a time.
module mgmt_host (
  // Clock.
  input  wire logic       clk_in,
  // Host register port, seen from the host.
  input  wire logic [7:0] reg_rdata_in,
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus from time zero.
  initial begin
    {reg_addr_out, reg_wdata_out, reg_wr_out, reg_rd_out} = '0;
  end

  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    {reg_addr_out, reg_wdata_out, reg_wr_out} <= {a, d, 1'b1};
    @(posedge clk_in);
    reg_wr_out <= 1'b0;
  endtask

  // Read data stand only in the cycle after the taking edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    {reg_addr_out, reg_rd_out} <= {a, 1'b1};
    @(posedge clk_in);
    reg_rd_out <= 1'b0;
    #1 d = reg_rdata_in;
  endtask

  // Select, trigger, then poll the first result byte until valid.
  // Drop counters carry no valid flag, so they are not polled.
  task automatic fetch(input logic [7:0] sel, input logic [7:0] cnt,
                       output logic [31:0] v, output logic ok);
    int n;
    ok = 1'b0;
    v = '0;
    wr(`REG_SEL, sel);
    wr(`REG_TRIG, cnt);
    for (n = 0; n < 8 && !ok; n++) begin
      rd(`REG_RES0, v[31:24]);
      ok = (sel == `SEL_DROP_GRP) || (v[30] === 1'b1);
    end
    rd(`REG_RES1, v[23:16]);
    rd(`REG_RES2, v[15:8]);
    rd(`REG_RES3, v[7:0]);
  endtask
endmodule

// *** testbench/tb_top.sv ***
`include "port_stats_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic            clk_in = 1'b0;
  logic            rst_n_in = 1'b0;
  logic [7:0]      addr, wdata, rdata;
  logic            wr, rd;
  logic [2:0]      rx_done, rx_crc, rx_b, rx_m, rx_da;
  logic [2:0][15:0] rx_et, rx_op;
  logic [2:0][10:0] rx_len, tx_len;
  logic [10:0]     max_len;
  logic [2:0]      tx_done, tx_ok, tx_ab, tx_hi, tx_pa, tx_b, tx_m, tx_df;
  logic [2:0][4:0] tx_cn;
  logic [2:0]      coll, late, hdx, tdrop, rdrop;
  int              bad_count = 0;
  int              checked = 0;
  logic [15:0]     rx_opc;

  // A 40 ns clock.
  always #20 clk_in = ~clk_in;

  port_stats port_stats_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata),
    .rx_done_in(rx_done), .rx_crc_ok_in(rx_crc), .rx_bcast_in(rx_b),
    .rx_mcast_in(rx_m), .rx_pause_da_in(rx_da), .rx_etype_in(rx_et),
    .rx_opcode_in(rx_op), .rx_len_in(rx_len), .max_frame_len_in(max_len),
    .tx_done_in(tx_done), .tx_ok_in(tx_ok), .tx_abandon_in(tx_ab),
    .tx_hi_prio_in(tx_hi), .tx_pause_in(tx_pa), .tx_bcast_in(tx_b),
    .tx_mcast_in(tx_m), .tx_deferred_in(tx_df), .tx_coll_num_in(tx_cn),
    .tx_len_in(tx_len), .tx_coll_in(coll), .tx_late_coll_in(late),
    .half_duplex_in(hdx), .tx_drop_in(tdrop), .rx_drop_in(rdrop));

  mgmt_host mgmt_host_inst (
    .clk_in(clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));

  task automatic end_sim();
    $display("Compared %0d, mismatched %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Receive frame end; flags are crc, bcast, mcast, pause address.
  task automatic rxf(input int p, input logic [3:0] f,
                     input logic [15:0] et, input logic [10:0] ln);
    @(posedge clk_in);
    {rx_done[p], rx_crc[p], rx_b[p], rx_m[p], rx_da[p]} <= {1'b1, f};
    {rx_et[p], rx_op[p], rx_len[p]} <= {et, rx_opc, ln};
    @(posedge clk_in);
    rx_done[p] <= 1'b0;
  endtask

  // Transmit frame end; flags are ok, abandon, hi, pause, bcast, mcast,
  // deferred.
  task automatic txf(input int p, input logic [6:0] f,
                     input logic [4:0] cn, input logic [10:0] ln);
    @(posedge clk_in);
    {tx_done[p], tx_ok[p], tx_ab[p], tx_hi[p]} <= {1'b1, f[6:4]};
    {tx_pa[p], tx_b[p], tx_m[p], tx_df[p]} <= f[3:0];
    {tx_cn[p], tx_len[p]} <= {cn, ln};
    @(posedge clk_in);
    tx_done[p] <= 1'b0;
  endtask

  // One-cycle pulse on collision, late, tx drop or rx drop lines.
  task automatic pl(input int k, input logic [2:0] m);
    @(posedge clk_in);
    case (k)
      0: coll <= m;
      1: late <= m;
      2: tdrop <= m;
      default: rdrop <= m;
    endcase
    @(posedge clk_in);
    {coll, late, tdrop, rdrop} <= '0;
  endtask

  // Fetch a counter; a port result must show valid set, overflow clear.
  task automatic gc(input logic drop, input logic [7:0] a,
                    input logic [29:0] e);
    logic [31:0] v;
    logic        ok;
    mgmt_host_inst.fetch(drop ? `SEL_DROP_GRP : `SEL_PORT_GRP, a, v, ok);
    if (!ok) begin
      bad_count++;
      end_sim();
    end else begin
      chk(v, drop ? {16'h0, e[15:0]} : {2'b01, e});
    end
  endtask

  // Main sequence.
  initial begin
    logic [10:0] lens [6];
    logic [7:0]  d;
    int          i;
    // One process owns every event input, all quiet from time zero.
    {rx_done, rx_crc, rx_b, rx_m, rx_da, rx_et, rx_op, rx_len} = '0;
    {tx_done, tx_ok, tx_ab, tx_hi, tx_pa, tx_b, tx_m, tx_df} = '0;
    {tx_cn, tx_len, coll, late, hdx, tdrop, rdrop} = '0;
    max_len = 11'h5f2;
    rx_opc = 16'h0001;
    lens = '{11'h064, 11'h0c8, 11'h12c, 11'h258, 11'h44c, 11'h640};
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rxf(0, 4'b0000, 16'h8808, 11'h040);
    rxf(1, 4'b1001, 16'h8808, 11'h040);
    rxf(2, 4'b1100, 16'h0800, 11'h064);
    rxf(2, 4'b1110, 16'h0800, 11'h064);
    rxf(2, 4'b1010, 16'h0800, 11'h064);
    rxf(2, 4'b0100, 16'h0800, 11'h064);
    rxf(2, 4'b1000, 16'h0800, 11'h064);
    for (i = 0; i < 6; i++) rxf(0, 4'b0000, 16'h0800, lens[i]);
    gc(1'b0, 8'h09, 30'h1);
    gc(1'b0, 8'h09, 30'h0);
    gc(1'b0, 8'h0e, 30'h1);
    for (i = 0; i < 5; i++) gc(1'b0, 8'h0f + 8'(i), 30'h1);
    gc(1'b0, 8'h2a, 30'h1);
    gc(1'b0, 8'h29, 30'h1);
    gc(1'b0, 8'h4b, 30'h2);
    gc(1'b0, 8'h4c, 30'h1);
    gc(1'b0, 8'h4d, 30'h1);
    gc(1'b0, 8'h4f, 30'h5);
    // A good control frame with a wrong opcode is no pause frame.
    rx_opc = 16'h0002;
    rxf(0, 4'b1001, 16'h8808, 11'h040);
    rx_opc = 16'h0001;
    gc(1'b0, 8'h0a, 30'h0);
    gc(1'b0, 8'h09, 30'h1);
    // Two long low-priority frames give a value spread over two bytes.
    for (i = 0; i < 2; i++) txf(0, 7'b1000000, 5'h0, 11'h7ff);
    txf(0, 7'b1010100, 5'h0, 11'h010);
    txf(0, 7'b1010010, 5'h0, 11'h010);
    txf(0, 7'b1010001, 5'h1, 11'h010);
    txf(0, 7'b1010000, 5'h3, 11'h010);
    txf(0, 7'b0010100, 5'h0, 11'h010);
    txf(0, 7'b0100000, 5'h10, 11'h010);
    txf(1, 7'b1011000, 5'h0, 11'h010);
    hdx <= 3'b001;
    pl(0, 3'b001);
    pl(0, 3'b001);
    pl(1, 3'b001);
    hdx <= 3'b000;
    pl(0, 3'b001);
    pl(2, 3'b001);
    pl(2, 3'b001);
    pl(3, 3'b101);
    gc(1'b0, 8'h14, 30'h0000_0ffe);
    gc(1'b0, 8'h15, 30'h40);
    gc(1'b0, 8'h18, 30'h1);
    gc(1'b0, 8'h19, 30'h1);
    gc(1'b0, 8'h1a, 30'h4);
    gc(1'b0, 8'h1b, 30'h1);
    gc(1'b0, 8'h1e, 30'h1);
    gc(1'b0, 8'h1f, 30'h1);
    gc(1'b0, 8'h1d, 30'h1);
    gc(1'b0, 8'h16, 30'h1);
    gc(1'b0, 8'h1c, 30'h2);
    gc(1'b0, 8'h35, 30'h10);
    gc(1'b0, 8'h37, 30'h1);
    gc(1'b1, 8'h00, 30'h2);
    gc(1'b1, 8'h00, 30'h2);
    gc(1'b1, 8'h03, 30'h1);
    gc(1'b1, 8'h05, 30'h1);
    // Result bytes are read-only and unmapped places read zero.
    mgmt_host_inst.wr(`REG_RES3, 8'hff);
    mgmt_host_inst.rd(`REG_RES3, d);
    chk({24'h0, d}, 32'h0000_0001);
    mgmt_host_inst.rd(8'h10, d);
    chk({24'h0, d}, 32'h0);
    mgmt_host_inst.rd(`REG_SEL, d);
    chk({24'h0, d}, 32'h0000_001d);
    end_sim();
  end
endmodule
